// ===== design/emw_window_defs.svh
// Purpose: Constants for the host memory window block.
// Assumes: One clock; host byte accesses and memory answers are on that clock.
// Notes:   Offsets are host byte-register offsets inside the window block.
// Behaviour
// - Four data bytes form one aligned dword
// - Two address bytes form one 15-bit address
// - Protected write updates data register, not memory
// - No-access read: no fetch, data untouched
// - Out-of-bounds auto-increment: reads advance, writes don't
// - Auto-increment mode is 32-bit plus advance
// - 32-bit read of byte 0 fetches dword
// - 32-bit write of byte 3 stores dword
// - 16-bit reads of bytes 0/2 fetch halfwords
// - 16-bit writes of bytes 1/3 store halfwords
// - 8-bit read fetches the matching byte
// - 8-bit write stores byte and data register
// - Address low bits zero; size in low bits
// - Window select picks one of two bases
`ifndef EMW_WINDOW_DEFS_SVH
`define EMW_WINDOW_DEFS_SVH

`define EMW_OFS_ADDR_LO   4'h2
`define EMW_OFS_ADDR_HI   4'h3
`define EMW_OFS_DATA_HI   2'h1
`define EMW_SIZE_LSB      0
`define EMW_SIZE_MSB      1
`define EMW_ADDR_LO_LSB   2
`define EMW_REGION_BIT    7
`define EMW_SIZE_8        2'h0
`define EMW_SIZE_16       2'h1
`define EMW_SIZE_32       2'h2
`define EMW_SIZE_AUTO     2'h3
`define EMW_RST_ADDR      13'h0000
`define EMW_RST_SIZE      2'h0
`define EMW_RST_BYTE      8'h00
`define EMW_HALF_STEP     15'h0002

`endif

// ===== design/emw_pkg.sv
// Purpose: Types for the host memory window block.
// Assumes: Constants come from emw_window_defs.svh.
// Notes:   One-hot state codes are written out.
package emw_pkg;

    typedef enum logic [1:0] {
        EMW_IDLE = 2'b01,
        EMW_MEM  = 2'b10
    } emw_state_e;

    typedef logic [7:0] emw_byte_t;

endpackage

// ===== design/emw_window.sv
// Purpose: Host byte window onto a 32-bit internal memory, with size modes and auto-increment.
// Assumes: Host and memory logic share mclk_i; one host byte access at a time.
// Notes:   Read data returns through a two-entry buffer; host_ready_o drops while it is full.
`timescale 1ns/10ps
`include "emw_window_defs.svh"

module emw_window #(
    parameter int ADDR_W    = 15,
    parameter int BUF_DEPTH = 2
) (
    input  wire logic                mclk_i,
    input  wire logic                srst_i,
    input  wire logic                host_valid_i,
    input  wire logic                host_write_i,
    input  wire logic [3:0]          host_offset_i,
    input  wire logic [7:0]          host_wdata_i,
    output logic                     host_ready_o,
    output logic                     rsp_valid_o,
    output logic [7:0]               rsp_data_o,
    input  wire logic                rsp_ready_i,
    input  wire logic [31:0]         base0_i,
    input  wire logic [31:0]         base1_i,
    input  wire logic [ADDR_W-1:0]   rd_limit0_i,
    input  wire logic [ADDR_W-1:0]   wr_limit0_i,
    input  wire logic [ADDR_W-1:0]   rd_limit1_i,
    input  wire logic [ADDR_W-1:0]   wr_limit1_i,
    output logic                     mem_req_o,
    output logic                     mem_write_o,
    output logic [31:0]              mem_addr_o,
    output logic [3:0]               mem_be_o,
    output logic [31:0]              mem_wdata_o,
    input  wire logic                mem_ack_i,
    input  wire logic [31:0]         mem_rdata_i,
    output logic [ADDR_W-1:0]        window_word_address_o,
    output logic                     region_o,
    output logic [1:0]               size_o,
    output logic                     blocked_o
);

    // Address split and buffer control are written for these sizes only
    if (ADDR_W != 15 || BUF_DEPTH != 2) begin : g_chk
        $error("emw_window supports only ADDR_W=15 and BUF_DEPTH=2");
    end

    localparam int DW_W = ADDR_W - 2;

    emw_pkg::emw_state_e state;
    emw_pkg::emw_state_e next_state;
    emw_pkg::emw_byte_t  data_q [4];
    emw_pkg::emw_byte_t  skid;
    emw_pkg::emw_byte_t  pdata;
    logic [DW_W-1:0]     dword;
    logic [1:0]          size;
    logic                region;
    logic [1:0]          lane;
    logic                skid_valid;
    logic                next_skid_valid;
    logic                acc;
    logic                is_data;
    logic [1:0]          k;
    logic [ADDR_W-1:0]   offs;
    logic                rd_ok;
    logic                wr_ok;
    logic                want_mem;
    logic                go_mem;
    logic                push;
    logic                pop;
    logic                adv;
    logic [31:0]         merged;

    // Lanes that one host byte access moves to or from memory
    function automatic logic [3:0] lane_mask(input logic [1:0] sz, input logic [1:0] kb);
        logic [3:0] m;
        m = 4'hf;
        if (sz == `EMW_SIZE_8) begin
            m = 4'h1 << kb;
        end else if (sz == `EMW_SIZE_16) begin
            m = kb[1] ? 4'hc : 4'h3;
        end
        return m;
    endfunction

    // Whether the byte touched triggers a memory access
    function automatic logic needs_mem(input logic wr, input logic [1:0] sz,
                                       input logic [1:0] kb);
        logic n;
        n = 1'b0;
        case (sz)
            `EMW_SIZE_8: begin
                n = 1'b1;
            end
            `EMW_SIZE_16: begin
                n = wr ? kb[0] : ~kb[0];
            end
            default: begin
                n = wr ? (kb == 2'h3) : (kb == 2'h0);
            end
        endcase
        return n;
    endfunction

    // One byte lane of a dword
    function automatic emw_pkg::emw_byte_t lane_byte(input logic [31:0] w,
                                                     input logic [1:0]  i);
        return w[i*8 +: 8];
    endfunction

    // Offset against the limit of the selected region; equal to the limit is outside
    function automatic logic below_limit(input logic              rg,
                                         input logic [ADDR_W-1:0] ofs,
                                         input logic [ADDR_W-1:0] lim0,
                                         input logic [ADDR_W-1:0] lim1);
        return rg ? (ofs < lim1) : (ofs < lim0);
    endfunction

    assign acc     = host_valid_i & host_ready_o;
    assign is_data = (host_offset_i[3:2] == `EMW_OFS_DATA_HI);
    assign k       = host_offset_i[1:0];
    assign pop     = rsp_valid_o & rsp_ready_i;

    // Byte offset of the access; the upper halfword sits two bytes on
    always_comb begin
        offs = {dword, 2'b00};
        if (size == `EMW_SIZE_16 && k[1]) begin
            offs = offs + `EMW_HALF_STEP;
        end
    end

    // Region permission, checked per direction
    assign rd_ok = below_limit(region, offs, rd_limit0_i, rd_limit1_i);
    assign wr_ok = below_limit(region, offs, wr_limit0_i, wr_limit1_i);

    assign want_mem = acc & is_data & needs_mem(host_write_i, size, k);
    assign go_mem   = want_mem & (host_write_i ? wr_ok : rd_ok);
    // Out-of-bounds reads of byte 3 still advance; writes only when writable
    assign adv      = acc & is_data & (size == `EMW_SIZE_AUTO) & (k == 2'h3)
                      & (~host_write_i | wr_ok);

    // Fetched lanes merged over the stored data register
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            merged[i*8 +: 8] = mem_be_o[i] ? lane_byte(mem_rdata_i, 2'(i)) : data_q[i];
        end
    end

    always_comb begin
        next_state = state;
        push       = 1'b0;
        pdata      = `EMW_RST_BYTE;
        case (state)
            emw_pkg::EMW_IDLE: begin
                if (go_mem) begin
                    next_state = emw_pkg::EMW_MEM;
                end else if (acc && !host_write_i) begin
                    push = 1'b1;
                    if (is_data) begin
                        pdata = data_q[k];
                    end else if (host_offset_i == `EMW_OFS_ADDR_LO) begin
                        pdata = {dword[5:0], size};
                    end else if (host_offset_i == `EMW_OFS_ADDR_HI) begin
                        pdata = {region, dword[DW_W-1:6]};
                    end
                end
            end
            emw_pkg::EMW_MEM: begin
                if (mem_ack_i) begin
                    next_state = emw_pkg::EMW_IDLE;
                    push       = ~mem_write_o;
                    pdata      = lane_byte(merged, lane);
                end
            end
            default: begin
                next_state = emw_pkg::EMW_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            state <= emw_pkg::EMW_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Address, size and window select registers
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            dword  <= `EMW_RST_ADDR;
            size   <= `EMW_RST_SIZE;
            region <= 1'b0;
        // Carry out of the top bit is dropped: the address wraps in its window
        end else if (adv) begin
            dword <= dword + 13'h0001;
        end else if (acc && host_write_i && host_offset_i == `EMW_OFS_ADDR_LO) begin
            dword[5:0] <= host_wdata_i[7:`EMW_ADDR_LO_LSB];
            size       <= host_wdata_i[`EMW_SIZE_MSB:`EMW_SIZE_LSB];
        end else if (acc && host_write_i && host_offset_i == `EMW_OFS_ADDR_HI) begin
            dword[DW_W-1:6] <= host_wdata_i[6:0];
            region          <= host_wdata_i[`EMW_REGION_BIT];
        end
    end

    // Data register: host writes always land; fetches fill only their lanes
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            for (int i = 0; i < 4; i++) begin
                data_q[i] <= `EMW_RST_BYTE;
            end
        end else if (acc && host_write_i && is_data) begin
            data_q[k] <= host_wdata_i;
        end else if (state == emw_pkg::EMW_MEM && mem_ack_i && !mem_write_o) begin
            for (int i = 0; i < 4; i++) begin
                data_q[i] <= merged[i*8 +: 8];
            end
        end
    end

    // Memory request, held until acknowledged
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            mem_req_o   <= 1'b0;
            mem_write_o <= 1'b0;
            mem_addr_o  <= 32'h0000_0000;
            mem_be_o    <= 4'h0;
            mem_wdata_o <= 32'h0000_0000;
            lane        <= 2'h0;
        end else if (go_mem) begin
            mem_req_o   <= 1'b1;
            mem_write_o <= host_write_i;
            // Dword-aligned: lanes select bytes, never the low address bits
            mem_addr_o  <= (region ? base1_i : base0_i)
                           + {{(32-ADDR_W){1'b0}}, dword, 2'b00};
            mem_be_o    <= lane_mask(size, k);
            lane        <= k;
            for (int i = 0; i < 4; i++) begin
                mem_wdata_o[i*8 +: 8] <= (i == int'(k)) ? host_wdata_i : data_q[i];
            end
        end else if (mem_ack_i) begin
            mem_req_o <= 1'b0;
        end
    end

    // Pulse when a data access that would reach memory is suppressed
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            blocked_o <= 1'b0;
        end else begin
            blocked_o <= want_mem & ~go_mem;
        end
    end

    // Skid entry keeps ready registered, at the cost of one more byte of storage
    // Two-entry return buffer: head register plus one skid entry
    always_comb begin
        next_skid_valid = skid_valid;
        if (pop || !rsp_valid_o) begin
            next_skid_valid = skid_valid & push;
        end else if (push) begin
            next_skid_valid = 1'b1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            rsp_valid_o <= 1'b0;
            rsp_data_o  <= `EMW_RST_BYTE;
            skid        <= `EMW_RST_BYTE;
            skid_valid  <= 1'b0;
        end else begin
            skid_valid <= next_skid_valid;
            if (pop || !rsp_valid_o) begin
                if (skid_valid) begin
                    rsp_data_o  <= skid;
                    rsp_valid_o <= 1'b1;
                    skid        <= pdata;
                end else begin
                    rsp_data_o  <= pdata;
                    rsp_valid_o <= push;
                end
            end else if (push) begin
                skid <= pdata;
            end
        end
    end

    // A stalled receiver stops new host accesses, so no read byte is lost
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            host_ready_o <= 1'b0;
        end else begin
            host_ready_o <= (next_state == emw_pkg::EMW_IDLE) & ~next_skid_valid & ~acc;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            window_word_address_o <= '0;
            region_o              <= 1'b0;
            size_o                <= `EMW_RST_SIZE;
        end else begin
            window_word_address_o <= {dword, 2'b00};
            region_o              <= region;
            size_o                <= size;
        end
    end

endmodule

// ===== dv/emw_mem_model.sv
// Purpose: Behavioural internal memory that answers the window's requests.
// Assumes: One request at a time; the dword index is taken from address bits 7:2.
// Notes:   Read data is inverted each idle cycle, so a stale word cannot pass for a fresh one.
`timescale 1ns/10ps
module emw_mem_model (
    input  wire logic        mclk_i,
    input  wire logic        srst_i,
    input  wire logic [3:0]  lat_i,
    input  wire logic        req_i,
    input  wire logic        we_i,
    input  wire logic [31:0] addr_i,
    input  wire logic [3:0]  be_i,
    input  wire logic [31:0] wdata_i,
    output logic             ack_o,
    output logic [31:0]      rdata_o
);
    logic [31:0] m [0:63];
    logic [3:0]  cnt;
    always @(posedge mclk_i) begin
        ack_o <= 1'b0;
        rdata_o <= ~rdata_o;
        if (srst_i) begin
            cnt <= 4'h0;
            rdata_o <= 32'h0;
        end else if (!req_i || ack_o) begin
            cnt <= 4'h0;
        end else if (cnt < lat_i) begin
            cnt <= cnt + 4'h1;
        end else begin
            ack_o <= 1'b1;
            rdata_o <= m[addr_i[7:2]];
            for (int b = 0; b < 4; b++) begin
                if (we_i && be_i[b]) begin
                    m[addr_i[7:2]][8*b+:8] <= wdata_i[8*b+:8];
                end
            end
        end
    end
endmodule

// ===== dv/emw_window_chk.sv
// Purpose: Port checks for the memory window.
// Assumes: Region bases are dword aligned.
// Notes:   Size is read at the take; it has settled by then.
`timescale 1ns/10ps
module emw_window_chk #(
    parameter int ADDR_W = 15
) (
    input wire logic              mclk_i,
    input wire logic              srst_i,
    input wire logic              host_valid_i,
    input wire logic              host_write_i,
    input wire logic [3:0]        host_offset_i,
    input wire logic              host_ready_o,
    input wire logic [31:0]       base0_i,
    input wire logic [31:0]       base1_i,
    input wire logic              mem_req_o,
    input wire logic              mem_write_o,
    input wire logic [31:0]       mem_addr_o,
    input wire logic [3:0]        mem_be_o,
    input wire logic              mem_ack_i,
    input wire logic [ADDR_W-1:0] window_word_address_o,
    input wire logic              region_o,
    input wire logic [1:0]        size_o,
    input wire logic              blocked_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (srst_i);
    sequence s_take(w, o);
        host_valid_i && host_ready_o && host_write_i == w && host_offset_i == o && size_o[1];
    endsequence
    a_addr_aligned: assert property (mem_req_o |-> mem_addr_o[1:0] == 2'b00)
        else $error("unaligned memory address");
    a_req_held: assert property (mem_req_o && !mem_ack_i |=> mem_req_o
        && $stable(mem_addr_o) && $stable(mem_be_o)) else $error("request moved early");
    a_take_closes: assert property (host_valid_i && host_ready_o |=> !host_ready_o)
        else $error("ready stayed high after take");
    a_fetch_dword: assert property (s_take(1'b0, 4'h4) |=> blocked_o
        || (mem_req_o && !mem_write_o && mem_be_o == 4'hf)) else $error("no dword fetch");
    a_no_fetch: assert property (s_take(1'b0, 4'h5) or s_take(1'b0, 4'h7) |=> !mem_req_o)
        else $error("stored byte read fetched");
    a_store_dword: assert property (s_take(1'b1, 4'h7) |=> blocked_o
        || (mem_req_o && mem_write_o && mem_be_o == 4'hf)) else $error("no dword store");
    a_half_lanes: assert property (mem_req_o && size_o == 2'h1 |-> mem_be_o inside {4'h3, 4'hc})
        else $error("bad halfword lanes");
    a_base_pick: assert property (mem_req_o && size_o != 2'h3 |-> mem_addr_o ==
        (region_o ? base1_i : base0_i) + 32'(window_word_address_o)) else $error("bad address");
    a_block_quiet: assert property (blocked_o |-> !mem_req_o)
        else $error("suppressed access reached memory");
endmodule
bind emw_window emw_window_chk #(.ADDR_W(ADDR_W)) u_chk (
    .mclk_i                (mclk_i),
    .srst_i                (srst_i),
    .host_valid_i          (host_valid_i),
    .host_write_i          (host_write_i),
    .host_offset_i         (host_offset_i),
    .host_ready_o          (host_ready_o),
    .base0_i               (base0_i),
    .base1_i               (base1_i),
    .mem_req_o             (mem_req_o),
    .mem_write_o           (mem_write_o),
    .mem_addr_o            (mem_addr_o),
    .mem_be_o              (mem_be_o),
    .mem_ack_i             (mem_ack_i),
    .window_word_address_o (window_word_address_o),
    .region_o              (region_o),
    .size_o                (size_o),
    .blocked_o             (blocked_o)
);

// ===== dv/tb_top.sv
// Purpose: Scenario bench for the memory window.
// Assumes: Region 0 reads below 40h, writes below 20h.
// Notes:   Memory is preloaded through the model's array.
`timescale 1ns/10ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_count++; \
    $display("Error t=%0t got %h exp %h", $time, g, e); end end
module tb_top;
    logic        mclk_i = 1'b0;
    logic        srst_i = 1'b1;
    logic        host_valid_i = 1'b0;
    logic        host_write_i = 1'b0;
    logic [3:0]  host_offset_i = 4'h0;
    logic [7:0]  host_wdata_i = 8'h00;
    logic        rsp_ready_i = 1'b1;
    logic [31:0] base0_i = 32'h0;
    logic [31:0] base1_i = 32'h80;
    logic [14:0] rd_limit0_i = 15'h40;
    logic [14:0] wr_limit0_i = 15'h20;
    logic [14:0] rd_limit1_i = 15'h40;
    logic [14:0] wr_limit1_i = 15'h40;
    logic        host_ready_o, rsp_valid_o, mem_req_o, mem_write_o, mem_ack_i, region_o, blocked_o;
    logic [7:0]  rsp_data_o;
    logic [31:0] mem_addr_o, mem_wdata_o, mem_rdata_i;
    logic [3:0]  mem_be_o;
    logic [3:0]  lat = 4'h0;
    logic [14:0] window_word_address_o;
    logic [1:0]  size_o;
    int          err_count = 0;
    int          total_checks = 0;
    emw_window u_dut (
        .mclk_i                (mclk_i),
        .srst_i                (srst_i),
        .host_valid_i          (host_valid_i),
        .host_write_i          (host_write_i),
        .host_offset_i         (host_offset_i),
        .host_wdata_i          (host_wdata_i),
        .host_ready_o          (host_ready_o),
        .rsp_valid_o           (rsp_valid_o),
        .rsp_data_o            (rsp_data_o),
        .rsp_ready_i           (rsp_ready_i),
        .base0_i               (base0_i),
        .base1_i               (base1_i),
        .rd_limit0_i           (rd_limit0_i),
        .wr_limit0_i           (wr_limit0_i),
        .rd_limit1_i           (rd_limit1_i),
        .wr_limit1_i           (wr_limit1_i),
        .mem_req_o             (mem_req_o),
        .mem_write_o           (mem_write_o),
        .mem_addr_o            (mem_addr_o),
        .mem_be_o              (mem_be_o),
        .mem_wdata_o           (mem_wdata_o),
        .mem_ack_i             (mem_ack_i),
        .mem_rdata_i           (mem_rdata_i),
        .window_word_address_o (window_word_address_o),
        .region_o              (region_o),
        .size_o                (size_o),
        .blocked_o             (blocked_o)
    );
    emw_mem_model u_mem (.mclk_i(mclk_i), .srst_i(srst_i), .lat_i(lat), .req_i(mem_req_o),
        .we_i(mem_write_o), .addr_i(mem_addr_o), .be_i(mem_be_o), .wdata_i(mem_wdata_o),
        .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));
    always #20 mclk_i = ~mclk_i;
    task automatic end_sim();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Byte access held until taken; one edge passes before the next may start
    task automatic acc(input logic w, input logic [3:0] o, input logic [7:0] d);
        int n = 0;
        host_valid_i <= 1'b1;
        host_write_i <= w;
        host_offset_i <= o;
        host_wdata_i <= d;
        @(posedge mclk_i);
        while (host_ready_o !== 1'b1 && n < 60) begin
            n++;
            @(posedge mclk_i);
        end
        if (host_ready_o !== 1'b1) begin
            err_count++;
            $display("Error t=%0t host access never taken", $time);
        end
        host_valid_i <= 1'b0;
        @(posedge mclk_i);
    endtask
    // Byte taken at the edge where valid and ready are both sampled high
    task automatic get(input logic [7:0] e);
        for (int n = 0; n < 60 && !(rsp_valid_o === 1'b1 && rsp_ready_i === 1'b1); n++)
            @(posedge mclk_i);
        if (rsp_valid_o !== 1'b1) begin
            err_count++;
            $display("Error t=%0t no read byte returned", $time);
        end
        `CHK(rsp_data_o, e)
        @(posedge mclk_i);
    endtask
    task automatic rd(input logic [3:0] o, input logic [7:0] e);
        acc(1'b0, o, 8'h00);
        get(e);
    endtask
    task automatic wr(input logic [3:0] o, input logic [7:0] d);
        acc(1'b1, o, d);
    endtask
    task automatic sync();
        for (int n = 0; n < 60 && host_ready_o !== 1'b1; n++) @(posedge mclk_i);
        if (host_ready_o !== 1'b1) begin
            err_count++;
            $display("Error t=%0t host side stayed closed", $time);
        end
        @(posedge mclk_i);
    endtask
    task automatic set_addr(input logic r, input logic [12:0] i, input logic [1:0] s);
        wr(4'h2, {i[5:0], s});
        wr(4'h3, {r, i[12:6]});
        sync();
        `CHK(window_word_address_o, {i, 2'b00})
        `CHK(size_o, s)
        `CHK(region_o, r)
    endtask
    task automatic t_rst();
        `CHK(window_word_address_o, 15'h0)
        wr(4'h2, 8'h02);
        rd(4'h2, 8'h02);
        rd(4'h3, 8'h00);
        rd(4'h7, 8'h00);
    endtask
    task automatic t_32();
        lat <= 4'h5;
        u_mem.m[1] = 32'h44332211;
        set_addr(1'b0, 13'h1, 2'h2);
        rd(4'h4, 8'h11);
        u_mem.m[1] = 32'h0;
        rd(4'h5, 8'h22);
        rd(4'h7, 8'h44);
        wr(4'h4, 8'ha1);
        wr(4'h5, 8'ha2);
        wr(4'h6, 8'ha3);
        `CHK(u_mem.m[1], 32'h0)
        wr(4'h7, 8'ha4);
        `CHK(blocked_o, 1'b0)
        sync();
        `CHK(u_mem.m[1], 32'ha4a3a2a1)
        lat <= 4'h0;
    endtask
    // Receiver stalls: two reads fill the buffer and the host side must close
    task automatic t_buf();
        rsp_ready_i <= 1'b0;
        acc(1'b0, 4'h5, 8'h00);
        acc(1'b0, 4'h6, 8'h00);
        repeat (4) @(posedge mclk_i);
        `CHK(host_ready_o, 1'b0)
        rsp_ready_i <= 1'b1;
        get(8'ha2);
        get(8'ha3);
    endtask
    task automatic t_16();
        u_mem.m[2] = 32'hddccbbaa;
        set_addr(1'b0, 13'h2, 2'h1);
        rd(4'h4, 8'haa);
        rd(4'h6, 8'hcc);
        u_mem.m[2] = 32'h0;
        rd(4'h7, 8'hdd);
        wr(4'h4, 8'h01);
        wr(4'h5, 8'h02);
        wr(4'h6, 8'h03);
        sync();
        `CHK(u_mem.m[2], 32'h00000201)
        wr(4'h7, 8'h04);
        sync();
        `CHK(u_mem.m[2], 32'h04030201)
    endtask
    task automatic t_8();
        u_mem.m[3] = 32'h87654321;
        set_addr(1'b0, 13'h3, 2'h0);
        for (int k = 0; k < 4; k++) begin
            rd(4'(4 + k), 8'(32'h87654321 >> (8 * k)));
            wr(4'(4 + k), 8'(8'hc0 + k));
            sync();
            `CHK(u_mem.m[3][8*k+:8], 8'(8'hc0 + k))
        end
    endtask
    task automatic t_auto();
        u_mem.m[4] = 32'h0d0c0b0a;
        set_addr(1'b0, 13'h4, 2'h3);
        for (int k = 0; k < 4; k++) rd(4'(4 + k), 8'(8'h0a + k));
        sync();
        `CHK(window_word_address_o, 15'h14)
        for (int k = 0; k < 4; k++) wr(4'(4 + k), 8'(8'he0 + k));
        sync();
        `CHK(u_mem.m[5], 32'he3e2e1e0)
        `CHK(window_word_address_o, 15'h18)
    endtask
    task automatic t_prot();
        rd_limit1_i <= 15'h0;
        u_mem.m[9] = 32'h99999999;
        set_addr(1'b0, 13'h9, 2'h2);
        for (int k = 0; k < 4; k++) wr(4'(4 + k), 8'(8'hf0 + k));
        `CHK(blocked_o, 1'b1)
        sync();
        `CHK(u_mem.m[9], 32'h99999999)
        rd(4'h5, 8'hf1);
        rd(4'h4, 8'h99);
        set_addr(1'b1, 13'h0, 2'h2);
        wr(4'h4, 8'h5a);
        acc(1'b0, 4'h4, 8'h00);
        `CHK(blocked_o, 1'b1)
        get(8'h5a);
        set_addr(1'b0, 13'h10, 2'h3);
        wr(4'h7, 8'h00);
        sync();
        `CHK(window_word_address_o, 15'h40)
        rd(4'h7, 8'h00);
        sync();
        `CHK(window_word_address_o, 15'h44)
    endtask
    initial begin
        #(40 * 20000);
        err_count++;
        $display("Error t=%0t watchdog expired", $time);
        end_sim();
    end
    initial begin
        repeat (5) @(posedge mclk_i);
        srst_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        t_rst();
        t_32();
        t_buf();
        t_16();
        t_8();
        t_auto();
        t_prot();
        end_sim();
    end
endmodule
